// ---- verilog/rbhc_top.sv ----
// Command interpreter for echo and error-history buffer reads and the 10-byte capacity read.
// Assumes synchronous inputs, CDB and nexus valid with cmd_valid_in, read data valid in the same
// cycle as mem_rd_out, and capacity inputs stable while a command runs.
`timescale 1ns/1ps
// Contract
// - Expander-communications mode is handled exactly like echo-buffer read mode.
// - Echo read returns lesser of low byte of requested length and last echo write length.
// - IDs 00h/01h return directory, 01h also snapshots; both need offset zero.
// - IDs 02h/03h return directory and take ownership; 03h snapshots; unconstrained.
// - History IDs return data from the given offset, 0000h to FFFFh.
// - FEh clears ownership, FFh also releases snapshot; offset ignored.
// - Constrained ID, foreign owner and existing snapshot give operation-in-progress error.
// - Offset not allowed or not acceptable gives invalid-field-in-CDB error.
// - Directory actions return the directory when ownership allows and the offset is zero.
// - Header: vendor bytes 0-7, version 8, flags 9, zeros, length 30-31 big-endian.
// - From byte 32, one 8-byte entry per supported ID 00h to EFh.
// - Opcode 25h returns the drive capacity information.
// - Capacity reply: max LBA bytes 0-3, block length 4-7, big-endian, data-in.
// - Reported block length counts user data only, without protection bytes.
module rbhc_top
	import rbhc_pkg::*;
#(
	parameter int          NEXUS_W   = 8,
	parameter int          HIST_BUFS = 1,
	parameter logic [23:0] HIST_LEN  = 24'h010000,
	parameter logic [7:0]  VERSION   = 8'h01,
	// Arbitrary neutral vendor identification, eight ASCII characters.
	parameter logic [63:0] VENDOR_ID = 64'h56_45_4E_44_4F_52_20_20
) (
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  cmd_valid_in,
	input  wire logic [CDB_BITS-1:0]   cmd_cdb_in,
	input  wire logic [NEXUS_W-1:0]    cmd_nexus_in,
	output logic                       cmd_ready_out,
	input  wire logic                  echo_written_in,
	input  wire logic [7:0]            echo_len_in,
	input  wire logic [31:0]           cap_max_lba_in,
	input  wire logic [31:0]           cap_block_len_in,
	input  wire logic                  cap_prot_en_in,
	output logic                       mem_rd_out,
	output logic [7:0]                 mem_id_out,
	output logic [23:0]                mem_addr_out,
	input  wire logic [7:0]            mem_data_in,
	output logic                       snap_take_out,
	output logic                       snap_release_out,
	output logic                       din_valid_out,
	output logic [7:0]                 din_data_out,
	input  wire logic                  din_ready_in,
	output logic                       done_out,
	output logic                       chk_out,
	output logic [3:0]                 sense_key_out,
	output logic [7:0]                 asc_out,
	output logic [7:0]                 ascq_out
);
	import rbhc_pkg::*;

	localparam int          DIR_LEN_I = DIR_HDR_BYTES + DIR_ENTRY_BYTES * (DIR_FIXED_IDS + HIST_BUFS);
	localparam logic [23:0] DIR_LEN   = 24'(DIR_LEN_I);
	localparam logic [15:0] DIR_FIELD = 16'(DIR_LEN_I - DIR_HDR_BYTES);
	localparam logic [7:0]  HIST_N    = 8'(HIST_BUFS);

	function automatic logic [7:0] cdb_byte(input logic [CDB_BITS-1:0] c, input int i);
		cdb_byte = c[CDB_BITS-1-8*i -: 8];
	endfunction : cdb_byte

	function automatic logic [7:0] be8(input logic [63:0] w, input logic [2:0] j);
		be8 = w[63-8*j -: 8];
	endfunction : be8

	function automatic logic [23:0] umin(input logic [23:0] a, input logic [23:0] b);
		umin = (a < b) ? a : b;
	endfunction : umin

	rbhc_state_t          state_r;
	rbhc_src_t            src_r;
	logic [CDB_BITS-1:0]  cdb_r;
	logic [NEXUS_W-1:0]   nexus_r;
	logic [NEXUS_W-1:0]   own_r;
	logic                 own_v_r;
	logic                 snap_r;
	logic                 retrieved_r;
	logic [23:0]          cnt_r;
	logic [23:0]          len_r;
	logic [23:0]          base_r;
	logic [7:0]           byte_r;
	logic                 buf_in_ready;

	// Command field decode.
	wire [7:0]  op      = cdb_byte(cdb_r, CDB_OPCODE);
	wire [7:0]  mode_b  = cdb_byte(cdb_r, CDB_MODE);
	wire [4:0]  mode    = mode_b[4:0];
	wire [7:0]  bid     = cdb_byte(cdb_r, CDB_BUFID);
	wire [23:0] ofs     = {cdb_byte(cdb_r, CDB_OFS), cdb_byte(cdb_r, CDB_OFS + 1),
		cdb_byte(cdb_r, CDB_OFS + 2)};
	wire [23:0] alloc   = {cdb_byte(cdb_r, CDB_ALLOC), cdb_byte(cdb_r, CDB_ALLOC + 1),
		cdb_byte(cdb_r, CDB_ALLOC + 2)};
	wire        is_rb   = (op == OP_READ_BUFFER);
	wire        is_cap  = (op == OP_READ_CAP10);
	wire        is_echo = is_rb && (mode == MODE_ECHO || mode == MODE_EXP_ECHO);
	wire        is_hist = is_rb && (mode == MODE_HISTORY);
	wire        id_dir  = (bid <= ID_DIR_OWN_SNAP);
	wire        id_own  = (bid == ID_DIR_OWN) || (bid == ID_DIR_OWN_SNAP);
	wire        id_snap = (bid == ID_DIR_SNAP) || (bid == ID_DIR_OWN_SNAP);
	wire        id_hbuf = (bid >= ID_HIST_LO) && (bid <= ID_HIST_HI);
	wire        id_clr  = (bid >= ID_CLR_OWN);
	wire        id_res  = !(id_dir || id_hbuf || id_clr);
	wire        hb_ok   = id_hbuf && ((bid - ID_HIST_LO) < HIST_N);

	// Foreign owner holding a snapshot blocks every constrained ID.
	wire busy = is_hist && !id_own && own_v_r && (own_r != nexus_r) && snap_r;
	wire ofs_bad = is_hist && (id_res
		|| (id_dir && ofs != 24'h000000)
		|| (id_hbuf && (!hb_ok || ofs > OFS_MAX || ofs >= HIST_LEN)));
	wire err_field = !busy && (ofs_bad || (is_rb && !is_echo && !is_hist)
		|| (is_echo && !echo_written_in));
	wire err_op    = !is_rb && !is_cap;
	wire ok        = !busy && !err_field && !err_op;

	// Reply length and byte source chosen at decode.
	wire [23:0] echo_len = umin({16'h0000, alloc[7:0]}, {16'h0000, echo_len_in});
	wire [23:0] len_sel  = is_cap ? CAP_REPLY_BYTES :
		is_echo ? echo_len :
		(is_hist && id_dir) ? umin(alloc, DIR_LEN) :
		(is_hist && id_hbuf) ? umin(alloc, HIST_LEN - ofs) : 24'h000000;
	wire rbhc_src_t src_sel = is_cap ? SRC_CAP : is_echo ? SRC_ECHO :
		(is_hist && id_hbuf) ? SRC_HIST : SRC_DIR;
	wire [23:0] base_sel = (is_hist && id_hbuf) ? ofs : 24'h000000;

	// Capacity reply bytes, protection bytes taken out of the block length.
	wire [31:0] user_blen = cap_prot_en_in ? (cap_block_len_in - PI_BYTES)
		: cap_block_len_in;
	wire [7:0]  cap_byte  = be8({cap_max_lba_in, user_blen}, cnt_r[2:0]);

	// Directory bytes: header then one entry per supported buffer ID.
	wire [23:0] ent_k    = (cnt_r - 24'(DIR_HDR_BYTES)) >> 3;
	wire [7:0]  ent_id   = (ent_k < 24'(DIR_FIXED_IDS)) ? ent_k[7:0]
		: ID_HIST_LO + ent_k[7:0] - 8'(DIR_FIXED_IDS);
	wire [31:0] ent_len  = (ent_k < 24'(DIR_FIXED_IDS)) ? {8'h00, DIR_LEN} : {8'h00, HIST_LEN};
	wire [7:0]  ent_byte = (cnt_r[2:0] == 3'h0) ? ent_id : be8({32'h0, ent_len}, cnt_r[2:0]);
	wire [7:0]  flags    = 8'(({7'h00, retrieved_r} << FLAG_RETRIEVED)
		| ({7'h00, snap_r} << FLAG_SOURCE) | (8'h01 << FLAG_CLR_SUP));
	wire [7:0]  dir_byte = (cnt_r < 24'h000008) ? be8(VENDOR_ID, cnt_r[2:0]) :
		(cnt_r == DIR_VERSION_IDX) ? VERSION :
		(cnt_r == DIR_FLAGS_IDX) ? flags :
		(cnt_r == DIR_LEN_MSB_IDX) ? DIR_FIELD[15:8] :
		(cnt_r == DIR_LEN_LSB_IDX) ? DIR_FIELD[7:0] :
		(cnt_r < 24'(DIR_HDR_BYTES)) ? 8'h00 : ent_byte;
	wire        src_mem  = (src_r == SRC_ECHO) || (src_r == SRC_HIST);
	wire        last     = (cnt_r + 24'h000001 == len_r);
	wire        pushed   = (state_r == ST_PUSH) && buf_in_ready;
	wire        in_dec   = (state_r == ST_DECODE);

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r       <= ST_IDLE;
			cmd_ready_out <= 1'b1;
			cdb_r         <= '0;
			nexus_r       <= '0;
			src_r         <= SRC_CAP;
			len_r         <= '0;
			base_r        <= '0;
			cnt_r         <= '0;
		end else begin
			case (state_r)
				ST_IDLE: if (cmd_valid_in) begin
					cdb_r         <= cmd_cdb_in;
					nexus_r       <= cmd_nexus_in;
					cmd_ready_out <= 1'b0;
					state_r       <= ST_DECODE;
				end
				ST_DECODE: begin
					src_r   <= src_sel;
					len_r   <= len_sel;
					base_r  <= base_sel;
					cnt_r   <= '0;
					state_r <= (ok && len_sel != 24'h000000) ? ST_GEN : ST_IDLE;
					cmd_ready_out <= !(ok && len_sel != 24'h000000);
				end
				ST_GEN: state_r <= src_mem ? ST_MEMW : ST_PUSH;
				ST_MEMW: state_r <= ST_PUSH;
				ST_PUSH: if (buf_in_ready) begin
					cnt_r         <= cnt_r + 24'h000001;
					state_r       <= last ? ST_IDLE : ST_GEN;
					cmd_ready_out <= last;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Byte fetch: internal sources load directly, buffer sources via the read port.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			byte_r       <= '0;
			mem_rd_out   <= 1'b0;
			mem_id_out   <= '0;
			mem_addr_out <= '0;
		end else begin
			mem_rd_out <= (state_r == ST_GEN) && src_mem;
			if (state_r == ST_GEN && src_mem) begin
				mem_id_out   <= (src_r == SRC_HIST) ? bid : 8'h00;
				mem_addr_out <= base_r + cnt_r;
			end
			if (state_r == ST_GEN && !src_mem)
				byte_r <= (src_r == SRC_CAP) ? cap_byte : dir_byte;
			else if (state_r == ST_MEMW)
				byte_r <= mem_data_in;
		end
	end

	// Error-history ownership and snapshot state.
	wire act = in_dec && ok && is_hist;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			own_v_r          <= 1'b0;
			own_r            <= '0;
			snap_r           <= 1'b0;
			retrieved_r      <= 1'b0;
			snap_take_out    <= 1'b0;
			snap_release_out <= 1'b0;
		end else begin
			snap_take_out    <= act && id_snap;
			snap_release_out <= act && bid == ID_CLR_ALL;
			if (act && id_own) begin
				own_v_r <= 1'b1;
				own_r   <= nexus_r;
			end else if (act && id_clr) begin
				own_v_r <= 1'b0;
			end
			if (act && id_snap)
				snap_r <= 1'b1;
			else if (act && bid == ID_CLR_ALL)
				snap_r <= 1'b0;
			if (act && (id_snap || bid == ID_CLR_ALL))
				retrieved_r <= 1'b0;
			else if (pushed && last && src_r == SRC_HIST)
				retrieved_r <= 1'b1;
		end
	end

	// Completion status, one-cycle done with sense data held until the next command.
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_out      <= 1'b0;
			chk_out       <= 1'b0;
			sense_key_out <= SK_NONE;
			asc_out       <= ASC_NONE;
			ascq_out      <= ASCQ_NONE;
		end else begin
			done_out <= (in_dec && !(ok && len_sel != 24'h000000)) || (pushed && last);
			if (in_dec) begin
				chk_out       <= !ok;
				sense_key_out <= ok ? SK_NONE : SK_ILLEGAL;
				asc_out       <= err_op ? ASC_INV_OPCODE : (err_field ? ASC_INV_FIELD : ASC_NONE);
				ascq_out      <= busy ? ASCQ_OP_IN_PROG : ASCQ_NONE;
			end
		end
	end

	rbhc_skid #(.WIDTH(8)) u_skid (
		.clock_in     (clock_in),
		.rst_n_in     (rst_n_in),
		.in_valid_in  (state_r == ST_PUSH),
		.in_data_in   (byte_r),
		.in_ready_out (buf_in_ready),
		.out_valid_out(din_valid_out),
		.out_data_out (din_data_out),
		.out_ready_in (din_ready_in)
	);

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	AST_EXP_ECHO: assert property (in_dec && ok && is_rb && mode == MODE_EXP_ECHO
		|=> src_r == SRC_ECHO) else $error("expander mode not served as echo read");
	AST_ECHO_LEN: assert property (in_dec && ok && is_echo
		|=> len_r <= {16'h0000, $past(echo_len_in)} && len_r <= {16'h0000, $past(alloc[7:0])}
		&& (len_r == {16'h0000, $past(echo_len_in)} || len_r == {16'h0000, $past(alloc[7:0])}))
		else $error("echo length is not the lesser value");
	AST_SNAP_TAKE: assert property (act && id_snap
		|=> snap_take_out && snap_r ##1 !snap_take_out) else $error("snapshot not captured");
	AST_OWNER_SET: assert property (act && id_own
		|=> own_v_r && own_r == $past(nexus_r)) else $error("ownership not taken");
	AST_HIST_ADDR: assert property (mem_rd_out && src_r == SRC_HIST
		|-> mem_addr_out == base_r + cnt_r) else $error("history address not offset based");
	AST_CLEAR_ALL: assert property (act && bid == ID_CLR_ALL
		|=> !own_v_r && !snap_r && snap_release_out) else $error("clear all incomplete");
	AST_BUSY_ERR: assert property (in_dec && busy
		|=> done_out && chk_out && sense_key_out == SK_ILLEGAL && ascq_out == ASCQ_OP_IN_PROG
		&& $stable(own_r)) else $error("busy error not reported");
	AST_OFS_ERR: assert property (in_dec && is_hist && !busy
		&& id_dir && ofs != 24'h000000
		|=> done_out && chk_out && asc_out == ASC_INV_FIELD) else $error("bad offset accepted");
	AST_RES_ID: assert property (in_dec && is_hist && !busy && id_res
		|=> done_out && asc_out == ASC_INV_FIELD) else $error("reserved buffer ID accepted");
	AST_DIR_GO: assert property (act && id_dir && alloc != 24'h000000
		|=> state_r == ST_GEN && src_r == SRC_DIR) else $error("directory not returned");
	AST_DIR_LEN: assert property (state_r == ST_PUSH && src_r == SRC_DIR
		&& cnt_r == DIR_LEN_LSB_IDX
		|-> byte_r == DIR_FIELD[7:0]) else $error("directory length byte wrong");
	AST_CAP_BLEN: assert property (state_r == ST_PUSH && src_r == SRC_CAP
		&& cnt_r == 24'h000007
		|-> byte_r == 8'(cap_block_len_in - (cap_prot_en_in ? PI_BYTES : 32'h00000000)))
		else $error("block length byte wrong");
endmodule : rbhc_top

// ---- verilog/rbhc_pkg.sv ----
// Shared constants and types for the read-buffer, error-history and capacity command block.
// Assumes byte-wide data-in transfers and 10-byte command descriptor blocks.
package rbhc_pkg;
	localparam logic [7:0]  OP_READ_BUFFER  = 8'h3C;
	localparam logic [7:0]  OP_READ_CAP10   = 8'h25;
	localparam logic [4:0]  MODE_ECHO       = 5'h0A;
	localparam logic [4:0]  MODE_EXP_ECHO   = 5'h1A;
	localparam logic [4:0]  MODE_HISTORY    = 5'h1C;
	localparam logic [7:0]  ID_DIR          = 8'h00;
	localparam logic [7:0]  ID_DIR_SNAP     = 8'h01;
	localparam logic [7:0]  ID_DIR_OWN      = 8'h02;
	localparam logic [7:0]  ID_DIR_OWN_SNAP = 8'h03;
	localparam logic [7:0]  ID_HIST_LO      = 8'h10;
	localparam logic [7:0]  ID_HIST_HI      = 8'hEF;
	localparam logic [7:0]  ID_CLR_OWN      = 8'hFE;
	localparam logic [7:0]  ID_CLR_ALL      = 8'hFF;
	localparam logic [23:0] OFS_MAX         = 24'h00FFFF;
	localparam logic [3:0]  SK_NONE         = 4'h0;
	localparam logic [3:0]  SK_ILLEGAL      = 4'h5;
	localparam logic [7:0]  ASC_NONE        = 8'h00;
	localparam logic [7:0]  ASC_INV_OPCODE  = 8'h20;
	localparam logic [7:0]  ASC_INV_FIELD   = 8'h24;
	localparam logic [7:0]  ASCQ_NONE       = 8'h00;
	localparam logic [7:0]  ASCQ_OP_IN_PROG = 8'h16;
	localparam int          DIR_HDR_BYTES   = 32;
	localparam int          DIR_ENTRY_BYTES = 8;
	localparam int          DIR_FIXED_IDS   = 4;
	localparam logic [23:0] DIR_VERSION_IDX = 24'h000008;
	localparam logic [23:0] DIR_FLAGS_IDX   = 24'h000009;
	localparam logic [23:0] DIR_LEN_MSB_IDX = 24'h00001E;
	localparam logic [23:0] DIR_LEN_LSB_IDX = 24'h00001F;
	localparam int          FLAG_RETRIEVED  = 2;
	localparam int          FLAG_SOURCE     = 1;
	localparam int          FLAG_CLR_SUP    = 0;
	localparam logic [23:0] CAP_REPLY_BYTES = 24'h000008;
	localparam logic [31:0] PI_BYTES        = 32'h00000008;
	localparam int          CDB_OPCODE      = 0;
	localparam int          CDB_MODE        = 1;
	localparam int          CDB_BUFID       = 2;
	localparam int          CDB_OFS         = 3;
	localparam int          CDB_ALLOC       = 6;
	localparam int          CDB_BITS        = 80;

	typedef enum {ST_IDLE, ST_DECODE, ST_GEN, ST_MEMW, ST_PUSH} rbhc_state_t;
	typedef enum logic [1:0] {SRC_CAP, SRC_DIR, SRC_ECHO, SRC_HIST} rbhc_src_t;
endpackage : rbhc_pkg

// ---- verilog/rbhc_skid.sv ----
// Two-entry buffer on the data-in byte path with registered outputs.
// Assumes one clock; a stalled drain side holds data and lowers in_ready_out.
`timescale 1ns/1ps
module rbhc_skid #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	logic             spare_v_r;
	logic [WIDTH-1:0] spare_d_r;
	wire              pop  = out_valid_out & out_ready_in;
	wire              push = in_valid_in & ~spare_v_r;

	assign in_ready_out = ~spare_v_r;

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
			spare_v_r     <= 1'b0;
			spare_d_r     <= '0;
		end else if (spare_v_r) begin
			if (pop) begin
				out_data_out <= spare_d_r;
				spare_v_r    <= 1'b0;
			end
		end else if (push) begin
			if (!out_valid_out || pop) begin
				out_data_out  <= in_data_in;
				out_valid_out <= 1'b1;
			end else begin
				spare_d_r <= in_data_in;
				spare_v_r <= 1'b1;
			end
		end else if (pop) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule : rbhc_skid

// ---- verif/rbhc_mem_model.sv ----
// Byte store on the far side of the block's memory read port, for echo and history data.
// Assumes one clock; a byte shows with the read strobe and is held for one cycle after it.
`timescale 1ns/1ps
module rbhc_mem_model (
	input  wire logic        clock_in,
	input  wire logic        mem_rd_in,
	input  wire logic [7:0]  mem_id_in,
	input  wire logic [23:0] mem_addr_in,
	output logic      [7:0]  mem_data_out
);
	logic [7:0] held_r = 8'h00;
	logic       hold_r = 1'b0;
	wire  [7:0] word_now = mem_id_in + mem_addr_in[7:0] + mem_addr_in[15:8];
	// Outside its hold time the bus shows the inverse of the last byte, so stale reads show up.
	assign mem_data_out = mem_rd_in ? word_now : (hold_r ? held_r : ~held_r);
	always_ff @(posedge clock_in) begin
		hold_r <= mem_rd_in;
		if (mem_rd_in) begin
			held_r <= word_now;
		end
	end
endmodule : rbhc_mem_model

// ---- verif/tb.sv ----
// Self-checking bench for the read-buffer, error-history and capacity command block.
// Assumes the memory model as data source and a data-in sink that can stall.
`timescale 1ns/1ps
module tb;
	import rbhc_pkg::*;
	// Arbitrary identification value.
	localparam logic [63:0] VEND = 64'h51_52_53_54_55_56_57_58;
	localparam logic [7:0]  VER  = 8'h07;
	localparam int          NDIR = DIR_HDR_BYTES + DIR_ENTRY_BYTES * (DIR_FIXED_IDS + 1);
	localparam logic [7:0]  RB   = OP_READ_BUFFER;
	localparam logic [4:0]  EH   = MODE_HISTORY;
	logic clock_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0, cmd_ready_out;
	logic [79:0] cmd_cdb_in = '0;
	logic [7:0]  cmd_nexus_in = '0, echo_len_in = '0, mem_id_out, mem_data_in, din_data_out;
	logic echo_written_in = 1'b0, cap_prot_en_in = 1'b0, din_ready_in = 1'b1, stall = 1'b0;
	logic [31:0] cap_max_lba_in = '0, cap_block_len_in = '0;
	logic [23:0] mem_addr_out;
	logic mem_rd_out, snap_take_out, snap_release_out, din_valid_out, done_out, chk_out;
	logic [3:0] sense_key_out, st_key;
	logic [7:0] asc_out, ascq_out, st_asc, st_ascq;
	logic [1:0] pace_r = 2'h0;
	logic st_chk, took, rel;
	logic [7:0] rx[$];
	int err_count = 0;
	int check_count = 0;

	rbhc_top #(.HIST_BUFS(1), .VERSION(VER), .VENDOR_ID(VEND)) u_rbhc_top (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in),
		.cmd_cdb_in(cmd_cdb_in), .cmd_nexus_in(cmd_nexus_in), .cmd_ready_out(cmd_ready_out),
		.echo_written_in(echo_written_in), .echo_len_in(echo_len_in),
		.cap_max_lba_in(cap_max_lba_in), .cap_block_len_in(cap_block_len_in),
		.cap_prot_en_in(cap_prot_en_in), .mem_rd_out(mem_rd_out), .mem_id_out(mem_id_out),
		.mem_addr_out(mem_addr_out), .mem_data_in(mem_data_in), .snap_take_out(snap_take_out),
		.snap_release_out(snap_release_out), .din_valid_out(din_valid_out),
		.din_data_out(din_data_out), .din_ready_in(din_ready_in), .done_out(done_out),
		.chk_out(chk_out), .sense_key_out(sense_key_out), .asc_out(asc_out), .ascq_out(ascq_out)
	);
	rbhc_mem_model u_rbhc_mem_model (.clock_in(clock_in), .mem_rd_in(mem_rd_out),
		.mem_id_in(mem_id_out), .mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in));

	always #5 clock_in = ~clock_in;
	// When stalling, the sink takes one byte in four cycles so the buffer fills up.
	always @(posedge clock_in) begin
		pace_r       <= pace_r + 2'h1;
		din_ready_in <= !stall || (pace_r == 2'h0);
	end

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic do_cmd(input logic [7:0] op, input logic [4:0] md, input logic [7:0] id,
			input logic [23:0] ofs, input logic [23:0] alloc, input logic [7:0] nx);
		int n;
		int tail;
		rx.delete();
		took = 1'b0;
		rel = 1'b0;
		tail = -1;
		@(posedge clock_in);
		cmd_cdb_in   <= {op, 3'h0, md, id, ofs, alloc, 8'h00};
		cmd_nexus_in <= nx;
		cmd_valid_in <= 1'b1;
		for (n = 0; n < 20 && cmd_ready_out !== 1'b1; n++) begin
			@(negedge clock_in);
		end
		if (cmd_ready_out !== 1'b1) begin
			err_count++;
			$display("Error at %0t: command not accepted", $time);
			wrap_up();
		end
		@(posedge clock_in);
		cmd_valid_in <= 1'b0;
		for (n = 0; n < 800 && tail != 0; n++) begin
			@(negedge clock_in);
			if (din_valid_out === 1'b1 && din_ready_in === 1'b1) rx.push_back(din_data_out);
			took = took | (snap_take_out === 1'b1);
			rel = rel | (snap_release_out === 1'b1);
			if (tail > 0) tail--;
			if (done_out === 1'b1 && tail < 0) begin
				tail = 12;
				{st_chk, st_key, st_asc, st_ascq} = {chk_out, sense_key_out, asc_out, ascq_out};
			end
		end
		if (tail != 0) begin
			err_count++;
			$display("Error at %0t: command did not finish", $time);
			wrap_up();
		end
	endtask : do_cmd

	task automatic exp_ok(input int n);
		cmp(st_chk, 1'b0, "check condition");
		cmp(rx.size(), n, "byte count");
	endtask : exp_ok

	task automatic exp_err(input logic [7:0] asc, input logic [7:0] ascq);
		cmp(st_chk, 1'b1, "check condition");
		cmp({st_key, st_asc, st_ascq}, {SK_ILLEGAL, asc, ascq}, "sense data");
		cmp(rx.size(), 0, "byte count");
	endtask : exp_err

	task automatic check_dir(input logic [7:0] flags);
		logic [7:0] ids[5] = '{ID_DIR, ID_DIR_SNAP, ID_DIR_OWN, ID_DIR_OWN_SNAP, ID_HIST_LO};
		exp_ok(NDIR);
		for (int i = 0; i < 8; i++) cmp(rx[i], VEND[63-8*i -: 8], "identification");
		cmp({rx[8], rx[9]}, {VER, flags}, "version and flags");
		for (int i = 10; i < 30; i++) cmp(rx[i], 8'h00, "zero byte");
		cmp({rx[30], rx[31]}, NDIR - 32, "directory length");
		for (int k = 0; k < 5; k++) cmp(rx[32+8*k], ids[k], "entry id");
	endtask : check_dir

	task automatic t_capacity();
		logic [63:0] cap_exp;
		for (int p = 0; p < 2; p++) begin
			@(posedge clock_in);
			stall            <= p[0];
			cap_max_lba_in   <= 32'h1234_5678;
			cap_block_len_in <= 32'h0000_0208;
			cap_prot_en_in   <= p[0];
			do_cmd(OP_READ_CAP10, 5'h00, 8'h00, 24'h0, 24'h0, 8'h01);
			exp_ok(8);
			cap_exp = {32'h1234_5678, (p == 0) ? 32'h0000_0208 : 32'h0000_0200};
			for (int i = 0; i < 8; i++) begin
				cmp(rx[i], cap_exp[63-8*i -: 8], "cap");
			end
		end
	endtask : t_capacity

	task automatic t_echo();
		logic [4:0] md[2] = '{MODE_ECHO, MODE_EXP_ECHO};
		do_cmd(RB, MODE_ECHO, 8'h00, 24'h0, 24'h3, 8'h01);
		exp_err(ASC_INV_FIELD, ASCQ_NONE);
		@(posedge clock_in);
		echo_written_in <= 1'b1;
		echo_len_in     <= 8'h05;
		for (int m = 0; m < 2; m++) begin
			for (int a = 3; a < 10; a += 6) begin
				do_cmd(RB, md[m], 8'h00, 24'h0, a[23:0], 8'h01);
				exp_ok(a < 5 ? a : 5);
				for (int i = 0; i < rx.size(); i++) cmp(rx[i], i, "echo byte");
			end
		end
	endtask : t_echo

	task automatic t_owner();
		do_cmd(RB, EH, ID_DIR, 24'h0, 24'h100, 8'h01);
		check_dir(8'h01);
		do_cmd(RB, EH, ID_DIR_OWN_SNAP, 24'h0, 24'h100, 8'h01);
		check_dir(8'h03);
		cmp(took, 1'b1, "snapshot taken");
		do_cmd(RB, EH, ID_HIST_LO, 24'h200, 24'h3, 8'h02);
		exp_err(ASC_NONE, ASCQ_OP_IN_PROG);
		do_cmd(RB, EH, ID_DIR, 24'h0, 24'h100, 8'h02);
		exp_err(ASC_NONE, ASCQ_OP_IN_PROG);
		do_cmd(RB, EH, ID_DIR_OWN, 24'h0, 24'h100, 8'h02);
		check_dir(8'h03);
		do_cmd(RB, EH, ID_HIST_LO, 24'h200, 24'h3, 8'h01);
		exp_err(ASC_NONE, ASCQ_OP_IN_PROG);
		do_cmd(RB, EH, ID_HIST_LO, 24'h200, 24'h3, 8'h02);
		exp_ok(3);
		for (int i = 0; i < 3; i++) cmp(rx[i], 8'h12 + i, "history byte");
		do_cmd(RB, EH, ID_CLR_OWN, 24'h123456, 24'h0, 8'h02);
		exp_ok(0);
		cmp(rel, 1'b0, "no release");
		do_cmd(RB, EH, ID_DIR, 24'h0, 24'h100, 8'h01);
		check_dir(8'h07);
		do_cmd(RB, EH, ID_CLR_ALL, 24'hABCDEF, 24'h0, 8'h01);
		exp_ok(0);
		cmp(rel, 1'b1, "release");
		do_cmd(RB, EH, ID_DIR_SNAP, 24'h0, 24'h100, 8'h02);
		check_dir(8'h03);
		cmp(took, 1'b1, "snapshot taken");
	endtask : t_owner

	task automatic t_fields();
		logic [7:0] bad[5] = '{8'h04, 8'h0F, 8'hF0, 8'hFD, 8'h11};
		do_cmd(RB, EH, ID_DIR_SNAP, 24'h000001, 24'h100, 8'h01);
		exp_err(ASC_INV_FIELD, ASCQ_NONE);
		for (int k = 0; k < 5; k++) begin
			do_cmd(RB, EH, bad[k], 24'h0, 24'h10, 8'h01);
			exp_err(ASC_INV_FIELD, ASCQ_NONE);
		end
		do_cmd(RB, EH, ID_HIST_LO, 24'h010000, 24'h2, 8'h01);
		exp_err(ASC_INV_FIELD, ASCQ_NONE);
		do_cmd(RB, EH, ID_HIST_LO, 24'h00FFFE, 24'h2, 8'h01);
		exp_ok(2);
		cmp({rx[0], rx[1]}, 16'h0D0E, "top of offset range");
		do_cmd(RB, 5'h02, 8'h00, 24'h0, 24'h10, 8'h01);
		exp_err(ASC_INV_FIELD, ASCQ_NONE);
		do_cmd(8'h9E, 5'h00, 8'h00, 24'h0, 24'h10, 8'h01);
		exp_err(ASC_INV_OPCODE, ASCQ_NONE);
	endtask : t_fields

	initial begin
		repeat (10) @(posedge clock_in);
		rst_n_in <= 1'b1;
		t_capacity();
		stall <= 1'b1;
		t_echo();
		t_owner();
		t_fields();
		wrap_up();
	end
endmodule : tb
